//--- bench/st_transceiver_config_register_tb_top.sv
// Self-checking bench of the transceiver mode setup register
`timescale 1ns/100ps
module st_transceiver_config_register_tb_top;
   // ==========================================================
   // Signals
   logic        clk_in, rst_in, mv, rv, lpc;
   logic [7:0]  mb, rb;
   logic [1:0]  mode;
   logic [4:0]  ev;
   logic [3:0]  s1, s2, q, o1, o2, oq;
   logic [11:0] wc;
   logic        sqv, cvi, ww, nt, l2l, adp, mfg, mfs, syn;
   int          n_mismatch, n_tests, n_sq, n_cv, n_ww, cyc;
   logic [7:0]  h, d;
   // ==========================================================
   // Design and controller model
   stc_config_reg stc_config_reg_i (.clk_in(clk_in), .rst_in(rst_in),
      .mon_byte_in(mb), .mon_valid_in(mv), .resp_byte_out(rb),
      .resp_valid_out(rv), .mode_in(mode), .frame_strobe_in(ev[4]),
      .mf_valid_in(ev[3]), .mf_err_in(ev[2]), .mf_end_in(ev[1]),
      .s1_in(s1), .s2_in(s2), .q_in(q), .cv_detect_in(ev[0]),
      .external_loop_close_in(lpc), .wander_cyc_in(wc),
      .sq_msg_valid_out(sqv), .sq_s1_out(o1), .sq_s2_out(o2),
      .sq_q_out(oq), .code_violation_indication_out(cvi),
      .wander_warning_a_out(ww), .nt_state_machine_out(nt),
      .loop_to_line_out(l2l), .adaptive_timing_out(adp),
      .mf_generate_out(mfg), .mf_sync_enable_out(mfs),
      .mf_synced_out(syn));
   stc_mon_ctl stc_mon_ctl_i (.clk_in(clk_in), .mon_byte_out(mb),
      .mon_valid_out(mv), .resp_byte_in(rb), .resp_valid_in(rv));
   // ==========================================================
   // Clock, pulse counters and hang guard
   initial
   begin
      clk_in = 1'b0;
      forever #12.5 clk_in = ~clk_in;
   end
   always @(posedge clk_in)
   begin
      n_sq += int'(sqv === 1'b1);
      n_cv += int'(cvi === 1'b1);
      n_ww += int'(ww === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // ==========================================================
   // Tasks
   task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask : chk
   task ev_pulse(input logic [4:0] v);
      @(posedge clk_in);
      ev <= v;
      @(posedge clk_in);
      ev <= 5'h00;
      repeat (2) @(posedge clk_in);
   endtask : ev_pulse
   // Write then a frame boundary so it takes effect
   task wrs(input logic [7:0] v);
      stc_mon_ctl_i.wr(4'h1, v);
      ev_pulse(5'h10);
   endtask : wrs
   task rdc(input logic [7:0] e);
      stc_mon_ctl_i.rd(4'h1, h, d);
      chk("head", 8'h81, h);
      chk("cfg", e, d);
   endtask : rdc
   task setw(input logic [11:0] v);
      @(posedge clk_in);
      wc <= v;
      repeat (3) @(posedge clk_in);
   endtask : setw
   // Strap is static, so each new strap gets a full reset
   task rst_mode(input logic [1:0] m);
      @(posedge clk_in);
      mode   <= m;
      rst_in <= 1'b1;
      repeat (20) @(posedge clk_in);
      rst_in <= 1'b0;
      @(posedge clk_in);
   endtask : rst_mode
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   // ==========================================================
   // Main sequence
   initial
   begin
      {mode, ev, s1, s2, q, lpc, wc} = '0;
      rst_in = 1'b1;
      {n_mismatch, n_tests, n_sq, n_cv, n_ww, cyc} = '0;
      rst_mode(2'h0);
      rdc(8'h00);
      ev_pulse(5'h10);
      chk("sync_en", 8'h1, 8'(mfs));
      stc_mon_ctl_i.wr(4'h1, 8'hff);
      chk("sync_en", 8'h1, 8'(mfs));
      rdc(8'h3e);
      stc_mon_ctl_i.rd(4'h2, h, d);
      chk("no_answer", 8'hxx, h);
      ev_pulse(5'h10);
      chk("sync_en", 8'h0, 8'(mfs));
      s1 <= 4'h5;
      s2 <= 4'ha;
      q  <= 4'h3;
      ev_pulse(5'h08);
      ev_pulse(5'h08);
      ev_pulse(5'h02);
      chk("synced", 8'h0, 8'(syn));
      chk("sq_count", 8'h0, 8'(n_sq));
      $display("disable test done");
      wrs(8'h00);
      ev_pulse(5'h08);
      ev_pulse(5'h08);
      chk("synced", 8'h1, 8'(syn));
      rdc(8'h80);
      ev_pulse(5'h04);
      chk("synced", 8'h1, 8'(syn));
      ev_pulse(5'h04);
      chk("synced", 8'h0, 8'(syn));
      $display("sync test done");
      ev_pulse(5'h02);
      chk("sq_count", 8'h1, 8'(n_sq));
      chk("sq_s1", 8'h5, 8'(o1));
      chk("sq_s2", 8'h0, 8'(o2));
      chk("sq_q", 8'h3, 8'(oq));
      ev_pulse(5'h02);
      chk("sq_count", 8'h1, 8'(n_sq));
      q <= 4'h6;
      ev_pulse(5'h02);
      chk("sq_count", 8'h2, 8'(n_sq));
      chk("sq_q", 8'h6, 8'(oq));
      wrs(8'h08);
      ev_pulse(5'h02);
      ev_pulse(5'h02);
      chk("sq_count", 8'h4, 8'(n_sq));
      chk("sq_s2", 8'ha, 8'(o2));
      chk("sq_q", 8'h6, 8'(oq));
      $display("sq test done");
      wrs(8'h04);
      ev_pulse(5'h01);
      wrs(8'h00);
      ev_pulse(5'h01);
      chk("cv_count", 8'h1, 8'(n_cv));
      lpc <= 1'b1;
      wrs(8'h32);
      chk("nt_sm", 8'h0, 8'(nt));
      chk("loop", 8'h1, 8'(l2l));
      chk("adaptive", 8'h0, 8'(adp));
      setw(12'h7d1);
      chk("warn", 8'h0, 8'(n_ww));
      setw(12'h000);
      rst_mode(2'h2);
      wrs(8'h32);
      chk("nt_sm", 8'h1, 8'(nt));
      chk("adaptive", 8'h1, 8'(adp));
      chk("mf_gen", 8'h1, 8'(mfg));
      lpc <= 1'b0;
      wrs(8'h80);
      chk("mf_gen", 8'h0, 8'(mfg));
      chk("loop", 8'h0, 8'(l2l));
      $display("mode test done");
      rst_mode(2'h1);
      wrs(8'h02);
      setw(12'h3e8);
      chk("warn", 8'h0, 8'(n_ww));
      setw(12'h3e9);
      chk("warn", 8'h1, 8'(n_ww));
      setw(12'h000);
      wrs(8'h00);
      setw(12'h3e9);
      chk("warn", 8'h1, 8'(n_ww));
      setw(12'h7d1);
      chk("warn", 8'h2, 8'(n_ww));
      $display("wander test done");
      report_and_stop();
   end
endmodule : st_transceiver_config_register_tb_top

//--- bench/stc_mon_ctl.sv
// Controller model that speaks register access messages on monitor bytes
`timescale 1ns/100ps
module stc_mon_ctl
(
   // Clock
   input  wire logic       clk_in,
   // Byte lanes
   output logic      [7:0] mon_byte_out,
   output logic            mon_valid_out,
   input  wire logic [7:0] resp_byte_in,
   input  wire logic       resp_valid_in
);
   initial mon_valid_out = 1'b0;
   initial mon_byte_out = 8'h00;
   // ==========================================================
   // One byte per pulse; lane then shows the inverse so stale data is not
   // mistaken for a repeat
   task send(input logic [7:0] b);
      @(posedge clk_in);
      mon_byte_out  <= b;
      mon_valid_out <= 1'b1;
      @(posedge clk_in);
      mon_valid_out <= 1'b0;
      mon_byte_out  <= ~b;
   endtask : send
   // Head then data, the only way in
   task wr(input logic [3:0] a, input logic [7:0] d);
      send({4'h8, a});
      send(d);
   endtask : wr
   // Request, then the two answer bytes under a bound
   task rd(input logic [3:0] a, output logic [7:0] h, output logic [7:0] d);
      int n;
      int k;
      n = 0;
      k = 0;
      h = 8'hxx;
      d = 8'hxx;
      send(8'h80);
      send({4'h0, a});
      while (n < 2 && k < 16)
      begin
         @(posedge clk_in);
         k++;
         if (resp_valid_in && n == 0) h = resp_byte_in;
         if (resp_valid_in && n == 1) d = resp_byte_in;
         if (resp_valid_in) n++;
      end
   endtask : rd
endmodule : stc_mon_ctl

//--- hdl/stc_config_reg.sv
// Transceiver mode setup register with its command parser and effects
`timescale 1ns/100ps
`include "stc_defs.svh"
module stc_config_reg
   import stc_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_in,
   // Monitor channel
   input  wire logic [7:0] mon_byte_in,
   input  wire logic       mon_valid_in,
   output logic      [7:0] resp_byte_out,
   output logic            resp_valid_out,
   // Line side events
   input  wire logic [1:0] mode_in,
   input  wire logic       frame_strobe_in,
   input  wire logic       mf_valid_in,
   input  wire logic       mf_err_in,
   input  wire logic       mf_end_in,
   input  wire logic [3:0] s1_in,
   input  wire logic [3:0] s2_in,
   input  wire logic [3:0] q_in,
   input  wire logic       cv_detect_in,
   input  wire logic       external_loop_close_in,
   input  wire logic [11:0] wander_cyc_in,
   // Effects
   output logic            sq_msg_valid_out,
   output logic      [3:0] sq_s1_out,
   output logic      [3:0] sq_s2_out,
   output logic      [3:0] sq_q_out,
   output logic            code_violation_indication_out,
   output logic            wander_warning_a_out,
   output logic            nt_state_machine_out,
   output logic            loop_to_line_out,
   output logic            adaptive_timing_out,
   output logic            mf_generate_out,
   output logic            mf_sync_enable_out,
   output logic            mf_synced_out
);
   // ==========================================================
   // State
   stc_state_t  st_r, st_nxt;
   logic [7:0]  cfg_r, cfg_nxt;      // Written value
   logic [7:0]  act_r, act_nxt;      // Value applied at frame boundary
   logic [7:0]  resp_r, resp_nxt;
   logic        rv_r, rv_nxt;
   logic        sync_r, sync_nxt;
   logic [1:0]  good_r, good_nxt;
   logic        err_r, err_nxt;
   logic [3:0]  ls1_r, ls1_nxt, lq_r, lq_nxt;
   logic        sqv_r, sqv_nxt;
   logic [11:0] s1o_r, s1o_nxt;
   logic        cvi_r, cvi_nxt, ww_r, ww_nxt, over_r, over_nxt;
   logic        lts, ltt, te, mf_on;
   logic [11:0] limit;

   assign lts   = (mode_in == `STC_MODE_LTS);
   assign ltt   = (mode_in == `STC_MODE_LTT);
   assign te    = (mode_in == `STC_MODE_TE);
   assign mf_on = ~act_r[`STC_BIT_MFD];
   // Wander limit picks the shorter window when the bit is set
   assign limit = act_r[`STC_BIT_MP] ? 12'(`STC_WANDER_SHORT_CYC)
                                     : 12'(`STC_WANDER_LONG_CYC);

   // ==========================================================
   // Next state of parser, register and line side effects
   always_comb
   begin
      st_nxt   = st_r;
      cfg_nxt  = cfg_r;
      act_nxt  = act_r;
      resp_nxt = resp_r;
      rv_nxt   = 1'b0;
      sync_nxt = sync_r;
      good_nxt = good_r;
      err_nxt  = err_r;
      ls1_nxt  = ls1_r;
      lq_nxt   = lq_r;
      sqv_nxt  = 1'b0;
      s1o_nxt  = s1o_r;
      cvi_nxt  = 1'b0;
      ww_nxt   = 1'b0;
      over_nxt = over_r;
      // Byte command parser, other addresses are silently dropped
      case (st_r)
         STC_IDLE:
            if (mon_valid_in && mon_byte_in == `STC_READ_HEAD)
               st_nxt = STC_RD_ADDR;
            else if (mon_valid_in && mon_byte_in == {`STC_CMD_HEAD,
                                                     `STC_CFG_ADDR})
               st_nxt = STC_WR_DATA;
         STC_WR_DATA:
            if (mon_valid_in)
            begin
               cfg_nxt = mon_byte_in & `STC_CFG_MASK;
               st_nxt  = STC_IDLE;
            end
         STC_RD_ADDR:
            if (mon_valid_in)
               st_nxt = (mon_byte_in == {4'h0, `STC_CFG_ADDR}) ?
                        STC_RESP_HEAD : STC_IDLE;
         STC_RESP_HEAD:
         begin
            resp_nxt = {`STC_CMD_HEAD, `STC_CFG_ADDR};
            rv_nxt   = 1'b1;
            st_nxt   = STC_RESP_DATA;
         end
         STC_RESP_DATA:
         begin
            // Top bit shows sync state instead of the stored bit
            resp_nxt = {sync_r, cfg_r[6:0]};
            rv_nxt   = 1'b1;
            st_nxt   = STC_IDLE;
         end
         default:
            st_nxt = STC_IDLE;
      endcase
      // Settings switch only on a frame edge, avoiding mid-frame glitches
      if (frame_strobe_in)
         act_nxt = cfg_r;
      // Multiframe synchronisation in terminal modes only
      if (!mf_on || lts)
      begin
         sync_nxt = 1'b0;
         good_nxt = 2'h0;
         err_nxt  = 1'b0;
      end
      else if (mf_valid_in)
      begin
         err_nxt = 1'b0;
         if (!sync_r)
         begin
            good_nxt = good_r + 2'h1;
            if (good_r + 2'h1 == `STC_SYNC_GOOD)
               sync_nxt = 1'b1;
         end
      end
      else if (mf_err_in)
      begin
         good_nxt = 2'h0;
         if (sync_r)
         begin
            err_nxt = 1'b1;
            if (err_r)
               sync_nxt = 1'b0;
         end
      end
      // S/Q messages at most once per multiframe, only with multiframing on
      if (mf_end_in && mf_on)
      begin
         ls1_nxt = s1_in;
         lq_nxt  = q_in;
         if (act_r[`STC_BIT_SQM])
         begin
            sqv_nxt = 1'b1;
            s1o_nxt = {s1_in, s2_in, q_in};
         end
         else if (s1_in != ls1_r || q_in != lq_r)
         begin
            sqv_nxt = 1'b1;
            s1o_nxt = {s1_in, 4'h0, q_in};
         end
      end
      // Violation indication per detected violation
      cvi_nxt = cv_detect_in & act_r[`STC_BIT_CVR];
      // Warning on the rising crossing, data path is left untouched
      over_nxt = ltt && (wander_cyc_in > limit);
      ww_nxt   = over_nxt & ~over_r;
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         st_r   <= STC_IDLE;
         cfg_r  <= `STC_CFG_RESET;
         act_r  <= `STC_CFG_RESET;
         resp_r <= 8'h00;
         rv_r   <= 1'b0;
         sync_r <= 1'b0;
         good_r <= 2'h0;
         err_r  <= 1'b0;
         ls1_r  <= 4'h0;
         lq_r   <= 4'h0;
         sqv_r  <= 1'b0;
         s1o_r  <= 12'h000;
         cvi_r  <= 1'b0;
         ww_r   <= 1'b0;
         over_r <= 1'b0;
         nt_state_machine_out <= 1'b0;
         loop_to_line_out     <= 1'b0;
         adaptive_timing_out  <= 1'b0;
         mf_generate_out      <= 1'b0;
         mf_sync_enable_out   <= 1'b0;
      end
      else
      begin
         st_r   <= st_nxt;
         cfg_r  <= cfg_nxt;
         act_r  <= act_nxt;
         resp_r <= resp_nxt;
         rv_r   <= rv_nxt;
         sync_r <= sync_nxt;
         good_r <= good_nxt;
         err_r  <= err_nxt;
         ls1_r  <= ls1_nxt;
         lq_r   <= lq_nxt;
         sqv_r  <= sqv_nxt;
         s1o_r  <= s1o_nxt;
         cvi_r  <= cvi_nxt;
         ww_r   <= ww_nxt;
         over_r <= over_nxt;
         nt_state_machine_out <= lts & act_r[`STC_BIT_SWAP];
         loop_to_line_out <= external_loop_close_in
                             & act_r[`STC_BIT_LOOP];
         // Only line side reads this bit as bus setup
         adaptive_timing_out <= lts & act_r[`STC_BIT_MP] & ~te;
         mf_generate_out    <= lts & mf_on;
         mf_sync_enable_out <= ~lts & mf_on;
      end
   end

   // ==========================================================
   // Outputs
   assign resp_byte_out  = resp_r;
   assign resp_valid_out = rv_r;
   assign mf_synced_out  = sync_r;
   assign sq_msg_valid_out = sqv_r;
   assign sq_s1_out = s1o_r[11:8];
   assign sq_s2_out = s1o_r[7:4];
   assign sq_q_out  = s1o_r[3:0];
   assign code_violation_indication_out = cvi_r;
   assign wander_warning_a_out = ww_r;

   // ==========================================================
   // Checks
   a_reset_clear: assert property (@(posedge clk_in)
      rst_in |=> cfg_r == 8'h00 && act_r == 8'h00)
      else $error("register not cleared by reset");
   a_resp_pair: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(rv_r) |-> resp_r == 8'h81 ##1 rv_r && resp_r[7] == $past(sync_r))
      else $error("read answer malformed");
   a_write_store: assert property (@(posedge clk_in) disable iff (rst_in)
      st_r == STC_WR_DATA && mon_valid_in
      |=> cfg_r == ($past(mon_byte_in) & 8'hbe))
      else $error("write not stored");
   a_sync_off: assert property (@(posedge clk_in) disable iff (rst_in)
      act_r[7] |=> !sync_r)
      else $error("sync while multiframing disabled");
   a_sq_quiet: assert property (@(posedge clk_in) disable iff (rst_in)
      act_r[7] && $past(act_r[7]) |-> !sqv_r)
      else $error("S/Q message while disabled");
   a_s2_absent: assert property (@(posedge clk_in) disable iff (rst_in)
      sqv_r && !$past(act_r[3]) |-> sq_s2_out == 4'h0)
      else $error("S2 in non-auto mode");
   a_cv_follow: assert property (@(posedge clk_in) disable iff (rst_in)
      cv_detect_in && act_r[2] |=> code_violation_indication_out)
      else $error("violation not reported");
   a_apply_edge: assert property (@(posedge clk_in) disable iff (rst_in)
      !frame_strobe_in |=> act_r == $past(act_r))
      else $error("setting changed off frame boundary");
   a_te_ignore: assert property (@(posedge clk_in) disable iff (rst_in)
      te |-> ##1 !ww_r && !adaptive_timing_out)
      else $error("multi-purpose bit used in TE");
   a_sync_gain: assert property (@(posedge clk_in) disable iff (rst_in)
      !sync_r ##1 sync_r |-> $past(mf_valid_in))
      else $error("sync without valid multiframe");
   c_read: cover property (@(posedge clk_in) rv_r ##1 rv_r);
   c_sync: cover property (@(posedge clk_in) $rose(sync_r));
   c_sq: cover property (@(posedge clk_in) sqv_r && act_r[3]);
   c_warn: cover property (@(posedge clk_in) ww_r);
endmodule : stc_config_reg

//--- hdl/stc_defs.svh
// Offsets, field positions, reset values and timing counts of the block
`ifndef STC_DEFS_SVH
`define STC_DEFS_SVH
// ==========================================================
// Register access message framing
`define STC_CMD_HEAD       4'h8
`define STC_READ_HEAD      8'h80
`define STC_CFG_ADDR       4'h1
// ==========================================================
// Mode setup field positions
`define STC_BIT_MFD        7
`define STC_BIT_SWAP       5
`define STC_BIT_LOOP       4
`define STC_BIT_SQM        3
`define STC_BIT_CVR        2
`define STC_BIT_MP         1
`define STC_CFG_MASK       8'hbe
`define STC_CFG_RESET      8'h00
// ==========================================================
// Strap codes
`define STC_MODE_TE        2'h0
`define STC_MODE_LTT       2'h1
`define STC_MODE_LTS       2'h2
// ==========================================================
// Timing
`define STC_CLK_MHZ        40
`define STC_WANDER_SHORT_US 25
`define STC_WANDER_LONG_US  50
`define STC_WANDER_SHORT_CYC (`STC_WANDER_SHORT_US * `STC_CLK_MHZ)
`define STC_WANDER_LONG_CYC  (`STC_WANDER_LONG_US * `STC_CLK_MHZ)
`define STC_SYNC_GOOD      2'h2
`endif

//--- hdl/stc_pkg.sv
// Types of the transceiver mode setup block
package stc_pkg;
   // ==========================================================
   // Command parser states
   typedef enum logic [2:0] {
      STC_IDLE,
      STC_WR_DATA,
      STC_RD_ADDR,
      STC_RESP_HEAD,
      STC_RESP_DATA
   } stc_state_t;
endpackage : stc_pkg
